/* rtl/cmr_consts.svh */
// Purpose: Constants for the move/return execute block
// Assumes: 14-bit instruction words, 15-bit program counter
// Notes:   Offsets are byte addresses on the AHB-Lite slave
`ifndef CMR_CONSTS_SVH
`define CMR_CONSTS_SVH
// Register byte offsets
`define CMR_OFF_INSTR     12'h000
`define CMR_OFF_ACC       12'h004
`define CMR_OFF_PTR0      12'h008
`define CMR_OFF_PTR1      12'h00C
`define CMR_OFF_PC        12'h010
`define CMR_OFF_STK_TOP   12'h014
`define CMR_OFF_OPTION    12'h018
`define CMR_OFF_IRQCTL    12'h01C
`define CMR_OFF_PWRCTL    12'h020
`define CMR_OFF_STATUS    12'h024
`define CMR_OFF_WRITE     12'h028
// Opcode patterns (14-bit words)
`define CMR_OP_NOP        14'h0000
`define CMR_OP_RETURN     14'h0008
`define CMR_OP_IRQ_RET    14'h0009
`define CMR_OP_OPTION     14'h0062
`define CMR_OP_RESET      14'h0001
// Top bits of the copy-to-file form and the indirect forms
`define CMR_OP_COPYF_HI   7'h01
`define CMR_OP_IND_HI     11'h003
`define CMR_OP_INDK_HI    7'h3F
// Field positions
`define CMR_IRQ_EN_BIT    7
`define CMR_RST_FLAG_BIT  2
`define CMR_FILE_ADDR_W   7
// Reset values
`define CMR_OPTION_RST    8'hFF
`define CMR_PWRCTL_RST    8'h0C
`define CMR_PC_RST        15'h0000
`define CMR_PTR_RST       16'h0000
`endif

/* rtl/cmr_exec.sv */
// Purpose: Executes the store, option-load, no-operation, software reset and
//          return instructions of an 8-bit core, with an AHB-Lite register view
// Assumes: Software writes an instruction word to the instruction register;
//          one write executes it; data memory lives outside and takes the
//          write strobe on mem_wr
// Notes:   Registers sit behind a zero-wait AHB-Lite slave
// Operation
// - Direct store copies accumulator into file register 0..127, one cycle, no flags
// - Pointer mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// - Offset form writes pointer plus signed -32..31 literal, pointer unchanged
// - Pointer ends plus one, minus one, or unchanged for offset form
// - Pre modes update before transfer, post modes transfer old value then update
// - Indirect port has no storage, access goes to pointer's address
// - Pointers are 16 bits and wrap modulo 65536
// - Indirect store and its pointer update leave all status flags alone
// - Option load copies accumulator to timer option register, one cycle, no flags
// - Software reset resets the device and clears the reset-instruction flag; the requested reset reloads power control to 0Ch, setting it again
// - Interrupt return pops stack into PC and sets enable bit 7, two cycles
// - Subroutine return pops stack into PC in two cycles, nothing else changes
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`include "cmr_consts.svh"

module cmr_exec (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [11:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output cmr_pkg::cmr_mem_wr_t     mem_wr,
    output logic                     soft_reset_req,
    output logic                     busy
);
    import cmr_pkg::*;

    localparam int PW = 16;

    // Bus address-phase capture
    logic        wr_pend_q;
    logic [11:0] addr_q;
    logic        rd_pend_q;

    // Architectural state
    logic [7:0]  acc_q;
    logic [PW-1:0] ptr_q [2];
    logic [14:0] pc_q;
    logic [14:0] stack_top_q;
    logic [7:0]  option_q;
    logic [7:0]  irqctl_q;
    logic [7:0]  pwrctl_q;
    logic [7:0]  status_q;
    logic        flush_q;
    logic        exec_go;
    logic [13:0] instr;

    // Decoded view of the instruction being executed
    logic          is_copy_file;
    logic          is_ind;
    logic          is_indk;
    logic          sel_n;
    cmr_ptr_mode_t mode;
    logic [5:0]    k_off;
    logic [PW-1:0] ptr_cur;
    logic [PW-1:0] ptr_inc;
    logic [PW-1:0] ptr_dec;
    logic [PW-1:0] ptr_new;
    logic [PW-1:0] eff_addr;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign busy      = flush_q;

    // Capture address phase; zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 12'h000;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            rd_pend_q <= hsel && htrans[1] && !hwrite;
            addr_q    <= haddr;
        end
    end

    // A write to the instruction register executes it in that data phase
    assign instr   = hwdata[13:0];
    assign exec_go = wr_pend_q && (addr_q == `CMR_OFF_INSTR);

    // Instruction field decode; the select bit picks the pointer in both
    // indirect forms, bit 2 here and bit 6 in the offset form
    always_comb begin
        is_copy_file = (instr[13:7] == `CMR_OP_COPYF_HI);
        is_ind       = (instr[13:3] == `CMR_OP_IND_HI);
        is_indk      = (instr[13:7] == `CMR_OP_INDK_HI);
        sel_n        = is_indk ? instr[6] : instr[2];
        mode         = cmr_ptr_mode_t'(instr[1:0]);
        k_off        = instr[5:0];
    end

    // Pointer arithmetic wraps naturally at 16 bits
    always_comb begin
        ptr_cur = ptr_q[sel_n];
        ptr_inc = PW'(ptr_cur + 16'h0001);
        ptr_dec = PW'(ptr_cur - 16'h0001);
        unique case (mode)
            CMR_PRE_INC, CMR_POST_INC: ptr_new = ptr_inc;
            CMR_PRE_DEC, CMR_POST_DEC: ptr_new = ptr_dec;
        endcase
        if (is_indk) begin
            // Sign-extended literal; the pointer itself is left alone
            eff_addr = PW'(ptr_cur + {{10{k_off[5]}}, k_off});
        end else if (mode == CMR_PRE_INC || mode == CMR_PRE_DEC) begin
            eff_addr = ptr_new;
        end else begin
            eff_addr = ptr_cur;
        end
    end

    // Data-memory write strobe; the indirect port is only a redirect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_wr <= '0;
        end else begin
            mem_wr.valid <= 1'b0;
            if (exec_go && !flush_q && is_copy_file) begin
                mem_wr <= '{1'b1, {9'h000, instr[6:0]}, acc_q};
            end else if (exec_go && !flush_q && (is_ind || is_indk)) begin
                mem_wr <= '{1'b1, eff_addr, acc_q};
            end
        end
    end

    // Pointer registers; one generate lane each
    for (genvar n = 0; n < 2; n++) begin : g_ptr
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ptr_q[n] <= `CMR_PTR_RST;
            end else if (wr_pend_q && addr_q == (n == 0 ? `CMR_OFF_PTR0 : `CMR_OFF_PTR1)) begin
                ptr_q[n] <= hwdata[PW-1:0];
            end else if (exec_go && !flush_q && is_ind && sel_n == 1'(n)) begin
                ptr_q[n] <= ptr_new;
            end
        end
    end

    // Accumulator and status: software-loaded, never touched by these ops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q    <= 8'h00;
            status_q <= 8'h00;
        end else begin
            if (wr_pend_q && addr_q == `CMR_OFF_ACC) begin
                acc_q <= hwdata[7:0];
            end
            // Flags only change by direct software write
            if (wr_pend_q && addr_q == `CMR_OFF_STATUS) begin
                status_q <= hwdata[7:0];
            end
        end
    end

    // Timer option register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            option_q <= `CMR_OPTION_RST;
        end else if (exec_go && !flush_q && instr == `CMR_OP_OPTION) begin
            option_q <= acc_q;
        end else if (wr_pend_q && addr_q == `CMR_OFF_OPTION) begin
            option_q <= hwdata[7:0];
        end
    end

    // Program counter, stack top and the discard slot after a return
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_q    <= `CMR_PC_RST;
            stack_top_q <= 15'h0000;
            flush_q     <= 1'b0;
        end else if (exec_go && flush_q) begin
            // Prefetched word is dropped, PC already holds the return address
            flush_q <= 1'b0;
        end else if (exec_go && (instr == `CMR_OP_RETURN || instr == `CMR_OP_IRQ_RET)) begin
            pc_q    <= stack_top_q;
            flush_q <= 1'b1;
        end else if (exec_go) begin
            pc_q <= 15'(pc_q + 15'h0001);
        end else begin
            if (wr_pend_q && addr_q == `CMR_OFF_PC) begin
                pc_q <= hwdata[14:0];
            end
            if (wr_pend_q && addr_q == `CMR_OFF_STK_TOP) begin
                stack_top_q <= hwdata[14:0];
            end
        end
    end

    // Interrupt control; of the instructions only the interrupt return sets the global enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irqctl_q <= 8'h00;
        end else if (exec_go && !flush_q && instr == `CMR_OP_IRQ_RET) begin
            irqctl_q[`CMR_IRQ_EN_BIT] <= 1'b1;
        end else if (wr_pend_q && addr_q == `CMR_OFF_IRQCTL) begin
            irqctl_q <= hwdata[7:0];
        end
    end

    // Power control flag and the reset request toward the reset controller
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwrctl_q       <= `CMR_PWRCTL_RST;
            soft_reset_req <= 1'b0;
        end else if (exec_go && !flush_q && instr == `CMR_OP_RESET) begin
            pwrctl_q[`CMR_RST_FLAG_BIT] <= 1'b0;
            soft_reset_req        <= 1'b1;
        end else if (wr_pend_q && addr_q == `CMR_OFF_PWRCTL) begin
            pwrctl_q <= hwdata[7:0];
        end
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_pend_q) begin
            unique case (addr_q)
                `CMR_OFF_ACC:    hrdata = {24'h000000, acc_q};
                `CMR_OFF_PTR0:   hrdata = {16'h0000, ptr_q[0]};
                `CMR_OFF_PTR1:   hrdata = {16'h0000, ptr_q[1]};
                `CMR_OFF_PC:     hrdata = {17'h00000, pc_q};
                `CMR_OFF_STK_TOP: hrdata = {17'h00000, stack_top_q};
                `CMR_OFF_OPTION: hrdata = {24'h000000, option_q};
                `CMR_OFF_IRQCTL: hrdata = {24'h000000, irqctl_q};
                `CMR_OFF_PWRCTL: hrdata = {24'h000000, pwrctl_q};
                `CMR_OFF_STATUS: hrdata = {24'h000000, status_q};
                `CMR_OFF_WRITE:  hrdata = {7'h00, mem_wr.valid, mem_wr.addr, mem_wr.data};
                default:         hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Direct store lands on the operand address with the accumulator value
    file_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && is_copy_file |=> mem_wr.valid
            && mem_wr.addr == {9'h000, $past(instr[6:0])} && mem_wr.data == $past(acc_q))
        else $error("direct store wrong");

    // Offset form leaves pointers as they were; a bus write cannot hit them then
    offset_ptr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && is_indk |=> ptr_q[0] == $past(ptr_q[0])
            && ptr_q[1] == $past(ptr_q[1]))
        else $error("offset form moved pointer");

    // Only the selected pointer may move
    other_ptr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && is_ind |=> ptr_q[~$past(sel_n)] == $past(ptr_q[~sel_n]))
        else $error("unselected pointer moved");

    // Pre modes write at the pointer's new value
    pre_inc_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && is_ind && mode == CMR_PRE_INC |=>
            mem_wr.valid && mem_wr.addr == ptr_q[$past(sel_n)])
        else $error("pre-increment address wrong");

    pre_dec_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && is_ind && mode == CMR_PRE_DEC |=>
            mem_wr.valid && mem_wr.addr == ptr_q[$past(sel_n)])
        else $error("pre-decrement address wrong");

    // Post modes write at the old value, one step behind the moved pointer
    post_inc_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && is_ind && mode == CMR_POST_INC |=>
            mem_wr.valid && mem_wr.addr == 16'(ptr_q[$past(sel_n)] - 16'h0001))
        else $error("post-increment address wrong");

    post_dec_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && is_ind && mode == CMR_POST_DEC |=>
            mem_wr.valid && mem_wr.addr == 16'(ptr_q[$past(sel_n)] + 16'h0001))
        else $error("post-decrement address wrong");

    // Pointer wraps from FFFF to 0000
    ptr_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && is_ind && ptr_cur == 16'hFFFF && !instr[0] |=>
            ptr_q[$past(sel_n)] == 16'h0000)
        else $error("pointer did not wrap");

    // Decrement modes step the selected pointer down by one
    ptr_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && is_ind && instr[0] |=>
            ptr_q[$past(sel_n)] == 16'($past(ptr_cur) - 16'h0001))
        else $error("pointer did not step down");

    // Stores never disturb status
    status_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && (is_ind || is_indk || is_copy_file) && addr_q != `CMR_OFF_STATUS |=>
            $stable(status_q))
        else $error("status changed by store");

    // Option load copies the accumulator
    option_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && instr == `CMR_OP_OPTION |=> option_q == $past(acc_q))
        else $error("option load wrong");

    // Software reset clears the flag and requests reset
    soft_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && instr == `CMR_OP_RESET |=>
            soft_reset_req && !pwrctl_q[`CMR_RST_FLAG_BIT])
        else $error("software reset missed");

    // The request holds until the external reset answers it; nothing else clears it
    reset_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        soft_reset_req |=> soft_reset_req)
        else $error("reset request dropped");

    // Interrupt return loads PC, sets enable, and swallows the next word
    irq_return_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && instr == `CMR_OP_IRQ_RET |=>
            pc_q == $past(stack_top_q) && irqctl_q[`CMR_IRQ_EN_BIT] && flush_q)
        else $error("interrupt return wrong");

    // Subroutine return leaves the interrupt enable alone
    return_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && instr == `CMR_OP_RETURN |=>
            pc_q == $past(stack_top_q) && $stable(irqctl_q) && flush_q)
        else $error("subroutine return wrong");

    // A discarded word changes nothing and empties the discard slot
    flush_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && flush_q |=>
            !mem_wr.valid && !flush_q && pc_q == $past(pc_q))
        else $error("discarded word took effect");

    // No-operation only steps the PC
    nop_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec_go && !flush_q && instr == `CMR_OP_NOP |=>
            pc_q == 15'($past(pc_q) + 15'h0001) && !mem_wr.valid)
        else $error("no-operation changed state");

endmodule // cmr_exec

/* rtl/cmr_pkg.sv */
// Purpose: Types shared by the move/return execute block
// Assumes: Constants come from cmr_consts.svh
// Notes:   Holds types only
package cmr_pkg;
    typedef enum logic [1:0] {
        CMR_PRE_INC,
        CMR_PRE_DEC,
        CMR_POST_INC,
        CMR_POST_DEC
    } cmr_ptr_mode_t;

    // One data-memory write produced by an executed instruction
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  data;
    } cmr_mem_wr_t;
endpackage

/* tb/cpu_move_return_execute_test.sv */
// Purpose: Self-checking bench for cmr_exec through its AHB-Lite register view
// Assumes: Zero-wait slave; an instruction runs when its write data phase ends
// Notes:   Expected values follow the instruction semantics, never the design outputs
`timescale 1ns/100ps
`include "cmr_consts.svh"

module cpu_move_return_execute_test;
    import cmr_pkg::*;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    cmr_mem_wr_t mem_wr;
    logic        soft_reset_req;
    logic        busy;
    cmr_mem_wr_t wr_seen;
    logic        busy_seen;
    logic [31:0] rd;
    int          num_errors;
    int          checked;

    // Reset view of every readable register except the last-write word, plus one unmapped word that must read zero
    localparam logic [11:0] rst_addr [10] = '{`CMR_OFF_ACC, `CMR_OFF_PTR0, `CMR_OFF_PTR1,
        `CMR_OFF_PC, `CMR_OFF_STK_TOP, `CMR_OFF_OPTION, `CMR_OFF_IRQCTL, `CMR_OFF_PWRCTL,
        `CMR_OFF_STATUS, 12'h040};
    localparam logic [31:0] rst_val [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFF,
        32'h0, 32'h0C, 32'h0, 32'h0};
    // Pointer start values chosen so three of the four modes cross a wrap point
    localparam logic [15:0] ind_start [4] = '{16'hFFFF, 16'h0000, 16'h1234, 16'h0000};
    localparam logic [15:0] ofs_ptr [2] = '{16'h0010, 16'hFFF0};
    localparam logic [5:0]  ofs_k [2] = '{6'h20, 6'h1F};

    // Only one slave, so its ready is the bus ready
    assign hready = hreadyout;

    cmr_exec u_cmr_exec (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .hsel           (hsel),
        .haddr          (haddr),
        .htrans         (htrans),
        .hwrite         (hwrite),
        .hsize          (hsize),
        .hwdata         (hwdata),
        .hready         (hready),
        .hrdata         (hrdata),
        .hreadyout      (hreadyout),
        .hresp          (hresp),
        .mem_wr         (mem_wr),
        .soft_reset_req (soft_reset_req),
        .busy           (busy)
    );

    // 10 MHz bus clock
    initial hclk = 1'h0;
    always #50 hclk = ~hclk;

    task automatic complete_run();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Bounded wait for hready at a rising edge; a stuck bus ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'h1 && n < 50);
        if (hready !== 1'h1) begin
            num_errors++;
            $display("[ERR] hready expected 1 seen %b", hready);
            complete_run();
        end
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        haddr  <= a;
        hwrite <= 1'h1;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask

    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
        haddr  <= a;
        hwrite <= 1'h0;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        wait_ready();
        d = hrdata;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        bus_rd(a, rd);
        chk(name, exp, rd);
    endtask

    // Runs one word; strobes are sampled at the end of the cycle after the data phase
    task automatic exec(input logic [13:0] op);
        bus_wr(`CMR_OFF_INSTR, {18'h0, op});
        @(posedge hclk);
        wr_seen   = mem_wr;
        busy_seen = busy;
    endtask

    task automatic do_reset();
        hresetn <= 1'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
    endtask

    // Main sequence
    initial begin
        logic [15:0] delta;
        logic [15:0] ea;
        logic [1:0]  m;
        hresetn = 1'h0;
        hsel    = 1'h1;
        haddr   = 12'h000;
        htrans  = 2'h0;
        hwrite  = 1'h0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        do_reset();
        for (int i = 0; i < 10; i++) begin
            rd_chk("reset value", rst_addr[i], rst_val[i]);
        end
        chk("hresp", 32'h0, {31'h0, hresp});
        exec(`CMR_OP_NOP);
        chk("nop store", 32'h0, {31'h0, wr_seen.valid});
        rd_chk("nop pc", `CMR_OFF_PC, 32'h1);
        // Nonzero flags, so a store that touched them would show
        bus_wr(`CMR_OFF_STATUS, 32'hC7);
        // Both ends of the file address range
        bus_wr(`CMR_OFF_ACC, 32'hA5);
        for (int i = 0; i < 2; i++) begin
            exec({`CMR_OP_COPYF_HI, (i == 0) ? 7'h00 : 7'h7F});
            chk("file valid", 32'h1, {31'h0, wr_seen.valid});
            chk("file addr", (i == 0) ? 32'h0 : 32'h7F, {16'h0, wr_seen.addr});
            chk("file data", 32'hA5, {24'h0, wr_seen.data});
        end
        rd_chk("file status", `CMR_OFF_STATUS, 32'hC7);
        // Every pointer mode, pre modes address the moved pointer
        for (int i = 0; i < 4; i++) begin
            m     = 2'(i);
            delta = m[0] ? 16'hFFFF : 16'h0001;
            ea    = m[1] ? ind_start[i] : ind_start[i] + delta;
            bus_wr(`CMR_OFF_PTR0, {16'h0, ind_start[i]});
            bus_wr(`CMR_OFF_ACC, {24'h0, 8'h30 + 8'(i)});
            exec({`CMR_OP_IND_HI, 1'h0, m});
            chk("ind valid", 32'h1, {31'h0, wr_seen.valid});
            chk("ind addr", {16'h0, ea}, {16'h0, wr_seen.addr});
            chk("ind data", {24'h0, 8'h30 + 8'(i)}, {24'h0, wr_seen.data});
            rd_chk("ind ptr", `CMR_OFF_PTR0, {16'h0, ind_start[i] + delta});
        end
        rd_chk("ind status", `CMR_OFF_STATUS, 32'hC7);
        // Offset extremes, the first wraps below 0000h and the second past FFFFh
        for (int i = 0; i < 2; i++) begin
            ea = ofs_ptr[i] + {{10{ofs_k[i][5]}}, ofs_k[i]};
            bus_wr(`CMR_OFF_PTR0, {16'h0, ofs_ptr[i]});
            exec({`CMR_OP_INDK_HI, 1'h0, ofs_k[i]});
            chk("ofs addr", {16'h0, ea}, {16'h0, wr_seen.addr});
            rd_chk("ofs ptr", `CMR_OFF_PTR0, {16'h0, ofs_ptr[i]});
        end
        // Pointer one is picked by the select bit; pointer zero must stay put
        bus_wr(`CMR_OFF_PTR1, 32'h0100);
        exec({`CMR_OP_IND_HI, 1'h1, 2'h2});
        chk("ptr1 addr", 32'h0100, {16'h0, wr_seen.addr});
        rd_chk("ptr1 step", `CMR_OFF_PTR1, 32'h0101);
        rd_chk("ptr0 kept", `CMR_OFF_PTR0, 32'hFFF0);
        rd_chk("last write", `CMR_OFF_WRITE, 32'h0001_0033);
        rd_chk("store pc", `CMR_OFF_PC, 32'hA);
        bus_wr(`CMR_OFF_ACC, 32'h4F);
        exec(`CMR_OP_OPTION);
        rd_chk("option", `CMR_OFF_OPTION, 32'h4F);
        rd_chk("option status", `CMR_OFF_STATUS, 32'hC7);
        // Subroutine return, then a store that must be thrown away
        bus_wr(`CMR_OFF_STK_TOP, 32'h1ABC);
        exec(`CMR_OP_RETURN);
        chk("ret busy", 32'h1, {31'h0, busy_seen});
        rd_chk("ret pc", `CMR_OFF_PC, 32'h1ABC);
        rd_chk("ret irq", `CMR_OFF_IRQCTL, 32'h0);
        exec({`CMR_OP_COPYF_HI, 7'h05});
        chk("dropped store", 32'h0, {31'h0, wr_seen.valid});
        rd_chk("dropped pc", `CMR_OFF_PC, 32'h1ABC);
        // Interrupt return sets the global enable
        bus_wr(`CMR_OFF_STK_TOP, 32'h0055);
        exec(`CMR_OP_IRQ_RET);
        rd_chk("irq ret pc", `CMR_OFF_PC, 32'h0055);
        rd_chk("irq ret enable", `CMR_OFF_IRQCTL, 32'h80);
        exec(`CMR_OP_NOP);
        exec(`CMR_OP_NOP);
        rd_chk("resume pc", `CMR_OFF_PC, 32'h0056);
        // Software reset, then the external reset it asks for
        exec(`CMR_OP_RESET);
        chk("reset req", 32'h1, {31'h0, soft_reset_req});
        rd_chk("reset flag", `CMR_OFF_PWRCTL, 32'h08);
        do_reset();
        chk("req cleared", 32'h0, {31'h0, soft_reset_req});
        rd_chk("pwrctl after", `CMR_OFF_PWRCTL, 32'h0C);
        rd_chk("option after", `CMR_OFF_OPTION, 32'hFF);
        complete_run();
    end
endmodule // cpu_move_return_execute_test
